// ==== logic/brinit_core.sv ====
// Reset sequencing, serial-memory load and register access gating for
// the bridge. Assumes the PCI target front end and register file run on
// this clock; pin inputs are synchronised here.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - First capability, power management, sits at 40h; list bit set by default.
// - Power management points to hot swap 48h, hot swap to data 4Ch.
// - Vital data next pointer resets to zero, ending the chain.
// - During serial load, PCI gets Retry outside host software reset and local acknowledge is withheld.
// - Configuration type 0 cycles reach the configuration registers.
// - Memory cycles matching base zero bits 31:8 or I/O matching base one hit.
// - Byte, word and 32-bit, burst or single PCI accesses all accepted.
// - Burst I/O register accesses get a disconnect.
// - Local register access answered only with chip select low.
// - Local accesses any width, burst or single; acknowledge ends each beat.
// - Adapter: PCI reset floats outputs, resets all, asserts local reset.
// - Adapter software reset resets local config and FIFOs, keeps PCI side and init flag.
// - Adapter software reset: PCI served, local ignored, until PCI clears.
// - Software reset with reload bit set reloads from serial memory.
// - Adapter: leaving D3 resets like PCI reset; not in host mode.
// - Host: PCI reset driven on local reset, software reset or own reset.
// - Host: local reset pin resets all; device drives it after 62 clocks.
// - Host software reset holds PCI master, config, FIFOs; asserts PCI reset.
// - Host software reset is cleared only from the local side.
// - Every PCI cycle outside device reset and host software reset is retried until init done is set.
// - Serial memory read as 16-bit words, upper half first, MSB first.
module brinit_core #(
  parameter logic [7:0] LOAD_REGS = brinit_pkg::SER_REG_COUNT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Pins
  input wire logic hostModePin,
  input wire logic pciRstPinN,
  input wire logic localResetInN,
  input wire logic configChipSelectN,
  input wire logic localStartN,
  input wire logic localBurstN,
  input wire logic serialDataIn,
  // Same-clock control from register file and PCI front end
  input wire logic serialMemPresent,
  input wire logic [1:0] pmState,
  input wire logic swResetWrite,
  input wire logic swResetFromPci,
  input wire logic swResetValue,
  input wire logic reloadConfigBit,
  input wire logic initDoneWrite,
  input wire logic initDoneValue,
  input wire logic externalResetReq,
  input wire logic pciReqValid,
  input wire logic pciCfgType0,
  input wire logic pciMemCycle,
  input wire logic pciIoCycle,
  input wire logic pciBurst,
  input wire logic [31:0] pciAddr,
  input wire logic [23:0] pciBaseAddrZero,
  input wire logic [23:0] pciBaseAddrOne,
  // Capability chain
  output logic capListEnable,
  output logic [7:0] capFirstPtr,
  output logic [7:0] powermgmtNextPtr,
  output logic [7:0] hotswapNextPtr,
  output logic [7:0] vitaldataNextPtr,
  // PCI target answers
  output logic pciRetry,
  output logic pciDisconnect,
  output logic pciCfgHit,
  output logic pciRegHit,
  output logic pciFloat,
  output logic pciRstOut,
  output logic pciRstOe,
  // Local bus
  output logic localTaN,
  output logic localRegHit,
  output logic localResetOut,
  output logic localResetOe,
  // Reset fan-out
  output logic deviceReset,
  output logic localCfgReset,
  output logic pciCfgReset,
  output logic pciMasterReset,
  output logic fifoReset,
  // Status and serial memory
  output logic initDone,
  output logic swReset,
  output logic loading,
  output logic serialClk,
  output logic serialCs,
  output logic [31:0] loadData,
  output logic loadValid
);
  // ***************************************************
  // State
  // ***************************************************
  typedef struct packed {
    logic hostS1, hostS2, prstS1, prstS2, lrstS1, lrstS2;
    logic ccsS1, ccsS2, tsS1, tsS2, burstS1, burstS2, serS1, serS2;
    logic [1:0] pmPrev;
    logic [3:0] pmHold;
    logic devRst, initDone, swReset, capEn;
    brinit_pkg::brinit_load_t ldState;
    logic serClk, serCs;
    logic [3:0] divCnt;
    logic [4:0] bitCnt;
    logic [7:0] regCnt;
    logic [31:0] shift, loadData;
    logic loadValid;
    logic [5:0] senseCnt, driveCnt;
    logic lrstOut, lrstOe, prstOut, prstOe, pciFloat;
    logic retry, disc, cfgHit, regHit;
    logic locPend;
    logic [2:0] beats;
    logic taN, locHit;
    logic cfgLocRst, cfgPciRst, masterRst, fifoRst;
    logic [1:0] lrstHold;
    logic busy;
    logic [7:0] capPtr;
  } brinit_state_t;

  brinit_state_t q, d;
  logic host, pinLrst, loadBusy, swRise, pmLeaveD3, locStart;

  always_comb
  begin
    d = q;
    // Two flops on every pin before use
    d.hostS1 = hostModePin;
    d.hostS2 = q.hostS1;
    d.prstS1 = pciRstPinN;
    d.prstS2 = q.prstS1;
    d.lrstS1 = localResetInN;
    d.lrstS2 = q.lrstS1;
    d.ccsS1 = configChipSelectN;
    d.ccsS2 = q.ccsS1;
    d.tsS1 = localStartN;
    d.tsS2 = q.tsS1;
    d.burstS1 = localBurstN;
    d.burstS2 = q.burstS1;
    d.serS1 = serialDataIn;
    d.serS2 = q.serS1;
    host = q.hostS2;
    // External low on the pin while we are not driving it; the hold
    // masks our own low still sitting in the synchroniser after release
    pinLrst = !q.lrstS2 && q.lrstOe && (q.lrstHold == 2'h0);
    loadBusy = (q.ldState == brinit_pkg::LD_RUN);
    // ***************************************************
    // Whole-device reset
    // ***************************************************
    d.pmPrev = pmState;
    pmLeaveD3 = (q.pmPrev == brinit_pkg::PM_STATE_D3)
      && (pmState != brinit_pkg::PM_STATE_D3);
    if (pmLeaveD3 && !host)
      d.pmHold = brinit_pkg::PM_RESET_CYCLES;
    else if (q.pmHold != 4'h0)
      d.pmHold = q.pmHold - 4'h1;
    d.devRst = host ? pinLrst
      : (!q.prstS2 || (q.pmHold != 4'h0));
    d.pciFloat = !host && !q.prstS2;
    // ***************************************************
    // Software reset bit
    // ***************************************************
    if (q.devRst)
      d.swReset = 1'b0;
    else if (swResetWrite && !host && swResetFromPci)
      d.swReset = swResetValue;
    else if (swResetWrite && host && !swResetFromPci)
      d.swReset = swResetValue;
    else if (swResetWrite && host && swResetValue)
      d.swReset = 1'b1;
    swRise = d.swReset && !q.swReset;
    // Init flag survives software reset, only local writes set it
    if (q.devRst)
      d.initDone = 1'b0;
    else if (initDoneWrite && !(q.swReset && !host))
      d.initDone = initDoneValue;
    // ***************************************************
    // Reset fan-out
    // ***************************************************
    d.cfgLocRst = q.devRst || (!host && q.swReset);
    d.cfgPciRst = q.devRst || (host && q.swReset);
    d.masterRst = q.devRst || (host && q.swReset);
    d.fifoRst = q.devRst || q.swReset;
    // Host drives PCI reset; adapter only listens
    d.prstOe = !host;
    d.prstOut = !(pinLrst || !q.lrstOe || q.swReset
      || externalResetReq);
    // ***************************************************
    // Local reset pin
    // ***************************************************
    d.lrstHold = q.lrstOe ? {1'b0, q.lrstHold[1]} : '1;
    if (!host)
    begin
      d.lrstOe = 1'b0;
      d.lrstOut = !(q.devRst || q.swReset);
      d.senseCnt = 6'h00;
      d.driveCnt = 6'h00;
    end
    else if (q.driveCnt != 6'h00)
    begin
      // Drive low for a fixed time, then let the pin go
      d.driveCnt = q.driveCnt - 6'h01;
      d.lrstOe = (q.driveCnt == 6'h01);
      d.lrstOut = 1'b0;
    end
    else if (pinLrst)
    begin
      d.senseCnt = q.senseCnt + 6'h01;
      if (q.senseCnt == brinit_pkg::LRST_SENSE_CLOCKS - 6'h01)
      begin
        d.lrstOe = 1'b0;
        d.lrstOut = 1'b0;
        d.driveCnt = brinit_pkg::LRST_DRIVE_CLOCKS;
        d.senseCnt = 6'h00;
      end
    end
    else
    begin
      d.senseCnt = 6'h00;
      d.lrstOe = 1'b1;
      d.lrstOut = 1'b1;
    end
    // ***************************************************
    // Serial memory load
    // ***************************************************
    d.loadValid = 1'b0;
    unique case (q.ldState)
      brinit_pkg::LD_IDLE:
      begin
        if (!q.devRst)
          d.ldState = serialMemPresent ? brinit_pkg::LD_RUN
            : brinit_pkg::LD_DONE;
        d.serCs = serialMemPresent && !q.devRst;
      end
      brinit_pkg::LD_RUN:
      begin
        d.divCnt = q.divCnt + 4'h1;
        if (q.divCnt == brinit_pkg::SER_HALF_PERIOD - 4'h1)
        begin
          d.divCnt = 4'h0;
          d.serClk = !q.serClk;
          if (!q.serClk)
          begin
            // Upper word lands first, each MSB first
            d.shift = {q.shift[30:0], q.serS2};
            d.bitCnt = q.bitCnt + 5'h01;
            if (q.bitCnt == brinit_pkg::SER_REG_BITS)
            begin
              d.loadData = {q.shift[30:0], q.serS2};
              d.loadValid = 1'b1;
              d.regCnt = q.regCnt + 8'h01;
              if (q.regCnt == LOAD_REGS - 8'h01)
              begin
                d.ldState = brinit_pkg::LD_DONE;
                d.serCs = 1'b0;
              end
            end
          end
        end
      end
      brinit_pkg::LD_DONE:
      begin
        d.serClk = 1'b0;
        if (swRise && reloadConfigBit)
        begin
          d.ldState = brinit_pkg::LD_RUN;
          d.serCs = 1'b1;
          d.regCnt = 8'h00;
          d.bitCnt = 5'h00;
          d.divCnt = 4'h0;
        end
      end
    endcase
    if (q.devRst)
    begin
      d.ldState = brinit_pkg::LD_IDLE;
      d.serClk = 1'b0;
      d.regCnt = 8'h00;
      d.bitCnt = 5'h00;
      d.divCnt = 4'h0;
    end
    // ***************************************************
    // PCI register access
    // ***************************************************
    d.retry = 1'b0;
    d.disc = 1'b0;
    d.cfgHit = 1'b0;
    d.regHit = 1'b0;
    if (pciReqValid && !q.devRst && !(host && q.swReset))
    begin
      if (loadBusy || !q.initDone)
        d.retry = 1'b1;
      else
      begin
        d.cfgHit = pciCfgType0;
        // Byte enables and memory burst length pass untouched
        d.regHit = (pciMemCycle && pciAddr[31:brinit_pkg::BAR_LSB]
          == pciBaseAddrZero) || (pciIoCycle
          && pciAddr[31:brinit_pkg::BAR_LSB] == pciBaseAddrOne);
        d.disc = pciIoCycle && pciBurst && (pciAddr[31:brinit_pkg::BAR_LSB]
          == pciBaseAddrOne);
      end
    end
    // ***************************************************
    // Local register access
    // ***************************************************
    locStart = !q.tsS2 && !q.ccsS2 && !q.locPend
      && (q.beats == 3'h0);
    d.taN = 1'b1;
    d.locHit = 1'b0;
    if (q.devRst || (!host && q.swReset))
    begin
      d.locPend = 1'b0;
      d.beats = 3'h0;
    end
    else if (locStart)
      d.locPend = 1'b1;
    else if (q.locPend && !loadBusy)
    begin
      // Acknowledge only once loading has finished
      d.locPend = 1'b0;
      d.beats = q.burstS2 ? brinit_pkg::LOCAL_SINGLE_BEAT
        : brinit_pkg::LOCAL_BURST_BEATS;
    end
    else if (q.beats != 3'h0)
    begin
      d.beats = q.beats - 3'h1;
      d.taN = 1'b0;
      d.locHit = 1'b1;
    end
    // Registered so these outputs come straight from flops
    d.capPtr = d.capEn ? brinit_pkg::CAP_PM_OFFSET
      : brinit_pkg::CAP_CHAIN_END;
    d.busy = (d.ldState == brinit_pkg::LD_RUN);
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '0;
      q.devRst <= 1'b1;
      q.capEn <= brinit_pkg::CAP_LIST_EN_RESET;
      q.capPtr <= brinit_pkg::CAP_PM_OFFSET;
      q.ldState <= brinit_pkg::LD_IDLE;
      q.prstS1 <= 1'b1;
      q.prstS2 <= 1'b1;
      q.lrstS1 <= 1'b1;
      q.lrstS2 <= 1'b1;
      q.ccsS1 <= 1'b1;
      q.ccsS2 <= 1'b1;
      q.tsS1 <= 1'b1;
      q.tsS2 <= 1'b1;
      q.burstS1 <= 1'b1;
      q.burstS2 <= 1'b1;
      q.lrstOut <= 1'b0;
      q.prstOut <= 1'b0;
      q.prstOe <= 1'b1;
      q.taN <= 1'b1;
    end
    else
      q <= d;
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  assign capListEnable = q.capEn;
  assign capFirstPtr = q.capPtr;
  assign powermgmtNextPtr = brinit_pkg::CAP_HOTSWAP_OFFSET;
  assign hotswapNextPtr = brinit_pkg::CAP_VITAL_OFFSET;
  assign vitaldataNextPtr = brinit_pkg::CAP_CHAIN_END;
  assign pciRetry = q.retry;
  assign pciDisconnect = q.disc;
  assign pciCfgHit = q.cfgHit;
  assign pciRegHit = q.regHit;
  assign pciFloat = q.pciFloat;
  assign pciRstOut = q.prstOut;
  assign pciRstOe = q.prstOe;
  assign localTaN = q.taN;
  assign localRegHit = q.locHit;
  assign localResetOut = q.lrstOut;
  assign localResetOe = q.lrstOe;
  assign deviceReset = q.devRst;
  assign localCfgReset = q.cfgLocRst;
  assign pciCfgReset = q.cfgPciRst;
  assign pciMasterReset = q.masterRst;
  assign fifoReset = q.fifoRst;
  assign initDone = q.initDone;
  assign swReset = q.swReset;
  assign loading = q.busy;
  assign serialClk = q.serClk;
  assign serialCs = q.serCs;
  assign loadData = q.loadData;
  assign loadValid = q.loadValid;

  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  chk_retry_before_init: assert property (
    pciReqValid && !q.initDone && !q.devRst && !(host && q.swReset)
    |=> pciRetry && !pciRegHit && !pciCfgHit)
    else $error("PCI cycle not retried before init done");
  chk_retry_while_load: assert property (
    pciReqValid && loadBusy && !q.devRst && !(host && q.swReset)
    |=> pciRetry)
    else $error("PCI cycle not retried during load");
  chk_no_ta_load: assert property (
    loadBusy && q.locPend |=> localTaN)
    else $error("Local acknowledge during load");
  chk_io_burst_disc: assert property (
    pciReqValid && pciIoCycle && pciBurst && q.initDone && !loadBusy
    && !q.devRst && !(host && q.swReset)
    && pciAddr[31:8] == pciBaseAddrOne |=> pciDisconnect && pciRegHit)
    else $error("Burst I/O register access not disconnected");
  chk_mem_bar_hit: assert property (
    pciRegHit |-> $past(pciMemCycle || pciIoCycle))
    else $error("Register hit without memory or I/O cycle");
  chk_ta_needs_cs: assert property (
    $rose(q.locPend) |-> $past(!configChipSelectN, 3))
    else $error("Local access taken without chip select");
  chk_release_after_load: assert property (
    $fell(q.locPend) && $past(!q.devRst && (host || !q.swReset))
    |-> $past(!loadBusy))
    else $error("Pending local access released during load");
  chk_adapter_sw_ignore: assert property (
    !host && q.swReset |=> localTaN)
    else $error("Local access answered in adapter software reset");
  chk_adapter_lrst: assert property (
    !host && $past(!host) && q.devRst |=> !localResetOut)
    else $error("Local reset not asserted on device reset");
  chk_host_pci_rst: assert property (
    host && $past(host) && q.swReset |=> !pciRstOut && !pciRstOe)
    else $error("PCI reset not driven in host software reset");
  chk_host_sw_hold: assert property (
    host && q.swReset && swResetWrite && swResetFromPci && !q.devRst
    |=> q.swReset)
    else $error("PCI side cleared host software reset");
  chk_sense_drive: assert property (
    host && q.senseCnt == 6'h3D && pinLrst && q.driveCnt == 6'h00
    && $past(host) |=> !localResetOe && !localResetOut)
    else $error("Local reset not driven after sensing");
  chk_pm_reset: assert property (
    !host && $past(!host) && pmLeaveD3 |=> ##1 q.devRst [*3])
    else $error("Leaving D3 did not reset the device");
endmodule // brinit_core
`default_nettype wire

// ==== logic/brinit_pkg.sv ====
// Constants, state types and timing counts for the bridge reset and
// initialisation block. Assumes a single 100 MHz clock domain.
`default_nettype none
package brinit_pkg;
  // ***************************************************
  // Capability chain
  // ***************************************************
  localparam logic [7:0] CAP_PM_OFFSET = 8'h40;
  localparam logic [7:0] CAP_HOTSWAP_OFFSET = 8'h48;
  localparam logic [7:0] CAP_VITAL_OFFSET = 8'h4C;
  localparam logic [7:0] CAP_CHAIN_END = 8'h00;
  localparam logic CAP_LIST_EN_RESET = 1'b1;
  localparam int CAP_LIST_BIT = 4;
  // ***************************************************
  // Power states
  // ***************************************************
  localparam logic [1:0] PM_STATE_D3 = 2'h3;
  localparam logic [3:0] PM_RESET_CYCLES = 4'h8;
  // ***************************************************
  // Local reset sensing and drive
  // ***************************************************
  localparam logic [5:0] LRST_SENSE_CLOCKS = 6'h3E;
  localparam logic [5:0] LRST_DRIVE_CLOCKS = 6'h3E;
  // ***************************************************
  // Serial memory
  // ***************************************************
  localparam int SER_WORD_BITS = 16;
  localparam logic [4:0] SER_REG_BITS = 5'h1F;
  localparam logic [3:0] SER_HALF_PERIOD = 4'h4;
  localparam logic [7:0] SER_REG_COUNT = 8'h17;
  // ***************************************************
  // Register access
  // ***************************************************
  localparam int BAR_LSB = 8;
  localparam logic [2:0] LOCAL_BURST_BEATS = 3'h4;
  localparam logic [2:0] LOCAL_SINGLE_BEAT = 3'h1;
  typedef enum logic [1:0] {LD_IDLE, LD_RUN, LD_DONE} brinit_load_t;
endpackage
`default_nettype wire

// ==== tb/brinit_core_tb_top.sv ====
// Self-checking bench for the reset and init block.
// Assumes a serial memory model on the serial pins.
`timescale 1ns/1ns
`default_nettype none
module brinit_core_tb_top;
  localparam logic [7:0] NREGS = 8'h02;
  localparam logic [3:0] KIND [5] = '{4'h8, 4'h4, 4'h5, 4'h2, 4'h3};
  localparam logic [3:0] ANS [5] = '{4'h4, 4'h2, 4'h2, 4'h2, 4'h3};
  logic clock = 1'b0;
  logic reset_n, hostModePin, pciRstPinN, extLrstN, configChipSelectN;
  logic localStartN, localBurstN, serialMemPresent, swResetWrite;
  logic swResetFromPci, swResetValue, reloadConfigBit, initDoneWrite;
  logic initDoneValue, externalResetReq, pciReqValid, pciCfgType0;
  logic pciMemCycle, pciIoCycle, pciBurst;
  logic [1:0] pmState;
  logic [31:0] pciAddr, rnd;
  logic [23:0] pciBaseAddrZero, pciBaseAddrOne;
  wire logic serialDataIn, localResetInN;
  logic capListEnable, pciRetry, pciDisconnect, pciCfgHit, pciRegHit;
  logic [7:0] capFirstPtr, powermgmtNextPtr, hotswapNextPtr, vitaldataNextPtr;
  logic pciFloat, pciRstOut, pciRstOe, localTaN, localRegHit, localResetOut;
  logic localResetOe, deviceReset, localCfgReset, pciCfgReset, pciMasterReset;
  logic fifoReset, initDone, swReset, loading, serialClk, serialCs, loadValid;
  logic [31:0] loadData;
  int mismatches = 0;
  int total_checks = 0;
  logic [3:0] expPci [$];
  logic [31:0] expLoad [$];
  always #5 clock = ~clock;
  // Open-drain style pin: device drive wins while its enable is low
  assign localResetInN = localResetOe ? extLrstN : localResetOut;
  brinit_core #(.LOAD_REGS(NREGS)) DUT (.*);
  brinit_sermem_model MEM (.clock(clock), .serialClk(serialClk),
    .serialCs(serialCs), .serialDataOut(serialDataIn));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic waitLvl(ref logic s, input logic v, input int lim);
    for (int i = 0; i < lim; i++)
    begin
      if (s === v)
        return;
      cyc(1);
    end
    check(s, v);
    report_and_stop;
  endtask
  task automatic doReset(input logic host);
    reset_n = 1'b0;
    hostModePin = host;
    cyc(16);
    reset_n = 1'b1;
    cyc(8);
    waitLvl(deviceReset, 1'b0, 40);
  endtask
  task automatic pushLoads;
    for (int k = 0; k < NREGS; k++)
      expLoad.push_back(32'h9D3C6A10 ^ {4{k[7:0]}});
  endtask
  task automatic pciReq(input logic [3:0] kind, input logic [23:0] bar,
    input logic [3:0] ans);
    rnd = $urandom;
    {pciCfgType0, pciMemCycle, pciIoCycle, pciBurst} = kind;
    pciAddr = {bar, rnd[7:0]};
    pciReqValid = 1'b1;
    // A zero answer means the cycle must go unclaimed
    if (ans != 4'h0)
      expPci.push_back(ans);
    cyc(1);
  endtask
  task automatic pciIdle;
    pciReqValid = 1'b0;
    cyc(3);
  endtask
  task automatic locAcc(input logic cs, input logic burst, input int beats);
    int n;
    n = 0;
    configChipSelectN = cs;
    localBurstN = burst;
    localStartN = 1'b0;
    cyc(1);
    localStartN = 1'b1;
    repeat (16)
    begin
      if (localTaN === 1'b0)
      begin
        n++;
        check(localRegHit, 1'b1);
      end
      cyc(1);
    end
    configChipSelectN = 1'b1;
    check(n, beats);
    cyc(1);
  endtask
  task automatic swWr(input logic fromPci, input logic v);
    swResetFromPci = fromPci;
    swResetValue = v;
    swResetWrite = 1'b1;
    cyc(1);
    swResetWrite = 1'b0;
    cyc(4);
  endtask
  // ****************************************
  // Result monitor
  // ****************************************
  always @(negedge clock)
  begin
    if ((pciRetry | pciCfgHit | pciRegHit) === 1'b1)
      check({pciRetry, pciCfgHit, pciRegHit, pciDisconnect},
        expPci.size() > 0 ? expPci.pop_front() : 4'hF);
    if (loadValid === 1'b1)
      check(loadData, expLoad.size() > 0 ? expLoad.pop_front() :
        ~loadData);
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    void'($urandom(86125));
    rnd = $urandom;
    {pciBaseAddrZero, pciBaseAddrOne} = {rnd[23:0], ~rnd[23:0]};
    {swResetWrite, swResetFromPci, swResetValue, reloadConfigBit} = 4'h0;
    {initDoneWrite, initDoneValue, externalResetReq, pciReqValid} = 4'h0;
    {pciCfgType0, pciMemCycle, pciIoCycle, pciBurst} = 4'h0;
    {pciRstPinN, extLrstN, configChipSelectN, localStartN} = 4'hF;
    localBurstN = 1'b1;
    serialMemPresent = 1'b1;
    pmState = 2'h0;
    pciAddr = 32'h0;
    pushLoads;
    doReset(1'b0);
    waitLvl(loading, 1'b0, 1500);
    check(capListEnable, 1'b1);
    check(capFirstPtr, 8'h40);
    check(powermgmtNextPtr, 8'h48);
    check(hotswapNextPtr, 8'h4C);
    check(vitaldataNextPtr, 8'h00);
    $display("test load and chain done");
    pciReq(4'h4, pciBaseAddrZero, 4'h8);
    pciIdle;
    initDoneValue = 1'b1;
    initDoneWrite = 1'b1;
    cyc(1);
    initDoneWrite = 1'b0;
    cyc(3);
    check(initDone, 1'b1);
    // Back to back with no idle gap between requests
    for (int i = 0; i < 5; i++)
      pciReq(KIND[i], i > 2 ? pciBaseAddrOne : pciBaseAddrZero, ANS[i]);
    pciReq(4'h4, pciBaseAddrOne, 4'h0);
    pciIdle;
    locAcc(1'b0, 1'b1, 1);
    locAcc(1'b0, 1'b0, 4);
    locAcc(1'b1, 1'b0, 0);
    $display("test access paths done");
    swWr(1'b1, 1'b1);
    check(swReset, 1'b1);
    check({localCfgReset, localResetOut}, 2'h2);
    check(initDone, 1'b1);
    pciReq(4'h4, pciBaseAddrZero, 4'h2);
    pciIdle;
    locAcc(1'b0, 1'b1, 0);
    swWr(1'b0, 1'b0);
    check(swReset, 1'b1);
    swWr(1'b1, 1'b0);
    check(swReset, 1'b0);
    reloadConfigBit = 1'b1;
    pushLoads;
    swWr(1'b1, 1'b1);
    waitLvl(loading, 1'b1, 20);
    pciReq(4'h4, pciBaseAddrZero, 4'h8);
    pciIdle;
    waitLvl(loading, 1'b0, 1500);
    swWr(1'b1, 1'b0);
    reloadConfigBit = 1'b0;
    serialMemPresent = 1'b0;
    $display("test adapter software reset done");
    pciRstPinN = 1'b0;
    cyc(4);
    check({pciFloat, deviceReset, localResetOut}, 3'h6);
    pciRstPinN = 1'b1;
    waitLvl(deviceReset, 1'b0, 20);
    pmState = 2'h3;
    cyc(4);
    pmState = 2'h0;
    waitLvl(deviceReset, 1'b1, 6);
    waitLvl(deviceReset, 1'b0, 20);
    $display("test adapter resets done");
    doReset(1'b1);
    swWr(1'b0, 1'b1);
    check({swReset, pciRstOut, pciRstOe}, 3'h4);
    check({pciCfgReset, pciMasterReset, fifoReset}, 3'h7);
    check(localCfgReset, 1'b0);
    swWr(1'b1, 1'b0);
    check(swReset, 1'b1);
    swWr(1'b0, 1'b0);
    check({swReset, pciRstOut}, 2'h1);
    externalResetReq = 1'b1;
    cyc(4);
    check(pciRstOut, 1'b0);
    externalResetReq = 1'b0;
    pmState = 2'h3;
    cyc(4);
    pmState = 2'h0;
    cyc(4);
    check(deviceReset, 1'b0);
    extLrstN = 1'b0;
    cyc(55);
    check({localResetOe, deviceReset, pciRstOut}, 3'h6);
    waitLvl(localResetOe, 1'b0, 20);
    extLrstN = 1'b1;
    waitLvl(localResetOe, 1'b1, 80);
    waitLvl(deviceReset, 1'b0, 30);
    $display("test host mode done");
    cyc(10);
    check(expPci.size() + expLoad.size(), 0);
    report_and_stop;
  end
endmodule // brinit_core_tb_top
`default_nettype wire

// ==== tb/brinit_sermem_model.sv ====
// Serial memory model feeding a fixed word pattern, MSB first.
// Assumes the reader keeps select high for one sequential read.
`timescale 1ns/1ns
`default_nettype none
module brinit_sermem_model (
  // Clock and serial pins
  input wire logic clock,
  input wire logic serialClk,
  input wire logic serialCs,
  output logic serialDataOut
);
  int bitIdx;
  int wordIdx;
  logic [31:0] shift;
  function automatic logic [31:0] wordAt(input int k);
    return 32'h9D3C6A10 ^ {4{k[7:0]}};
  endfunction
  initial serialDataOut = 1'b0;
  always @(posedge serialCs)
  begin
    bitIdx = 0;
    wordIdx = 0;
    shift = wordAt(0);
    serialDataOut = shift[31];
  end
  // Bits move on the falling edge so the rising edge sees them settled
  always @(negedge serialClk)
  begin
    if (serialCs)
    begin
      bitIdx++;
      if (bitIdx % 32 == 0)
      begin
        wordIdx++;
        shift = wordAt(wordIdx);
      end
      else
        shift = shift << 1;
      serialDataOut = shift[31];
    end
  end
  // Deselected line carries no stale data
  always @(posedge clock)
  begin
    if (!serialCs)
      serialDataOut <= ~serialDataOut;
  end
endmodule // brinit_sermem_model
`default_nettype wire
